// ### design/spi_pkg.sv
package spi_pkg;
  // register byte offsets
  localparam logic [11:0] SPI_CH0_CTRL_OFF = 12'h000;
  localparam logic [11:0] SPI_CH1_CTRL_OFF = 12'h004;
  localparam logic [11:0] SPI_CH0_SRC_OFF = 12'h008;
  localparam logic [11:0] SPI_CH1_SRC_OFF = 12'h00C;
  localparam logic [11:0] SPI_LINE_OFF = 12'h010;
  localparam logic [11:0] SPI_STAT_OFF = 12'h014;
  localparam logic [11:0] SPI_MASK_OFF = 12'h018;
  // control register fields
  localparam int SPI_IE_LSB = 0;
  localparam int SPI_IE_W = 4;
  localparam int SPI_GATE_BIT = 4;
  localparam int SPI_DESIG_LSB = 8;
  localparam int SPI_DESIG_W = 2;
  localparam logic [31:0] SPI_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SPI_MASK_RST = 32'h0000_0000;
  // source register: set by write-one, cleared by service pulse
  localparam int SPI_SRC_W = 4;
  localparam int SPI_SET_LSB = 0;
  localparam int SPI_SVC_LSB = 4;
  typedef enum logic [1:0] {
    SPI_COM1 = 2'h0,
    SPI_COM2 = 2'h1,
    SPI_COM3 = 2'h2,
    SPI_COM4 = 2'h3
  } spi_desig_t;
  typedef struct packed {
    logic [SPI_IE_W-1:0] enable;
    logic gate;
    spi_desig_t desig;
  } spi_chan_cfg_t;
endpackage : spi_pkg

// ### design/spi_chan_req.sv
`timescale 1ns/1ps
`default_nettype none
module spi_chan_req
  import spi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire spi_chan_cfg_t cfg,
  input wire logic [SPI_SRC_W-1:0] src_set,
  input wire logic [SPI_SRC_W-1:0] src_clr,
  output logic [SPI_SRC_W-1:0] src_q,
  output logic req
);
  // pending sources; set wins over a service in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= '0;
    end else if (ce) begin
      src_q <= (src_q & ~src_clr) | src_set;
    end
  end
  assign req = |(src_q & cfg.enable) & cfg.gate;
endmodule : spi_chan_req
`default_nettype wire

// ### design/spi_irq_out.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spi_irq_out
  import spi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serial_irq_line_a,
  output logic serial_irq_line_a_oe,
  output logic serial_irq_line_b,
  output logic serial_irq_line_b_oe,
  output logic irq
);
  spi_chan_cfg_t cfg_q [2];
  logic [SPI_SRC_W-1:0] src_q [2];
  logic [SPI_SRC_W-1:0] src_set [2];
  logic [SPI_SRC_W-1:0] src_clr [2];
  logic [1:0] req;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [1:0] req_prev_q;
  logic a_d, a_oe_d, b_d, b_oe_d;
  logic wr, rd_ok;
  logic [31:0] rdata_d;

  default clocking spi_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic on_line_a(input spi_desig_t d);
    on_line_a = (d == SPI_COM2) || (d == SPI_COM4);
  endfunction : on_line_a

  function automatic logic [31:0] cfg_word(input spi_chan_cfg_t c);
    cfg_word = '0;
    cfg_word[SPI_IE_LSB +: SPI_IE_W] = c.enable;
    cfg_word[SPI_GATE_BIT] = c.gate;
    cfg_word[SPI_DESIG_LSB +: SPI_DESIG_W] = c.desig;
  endfunction : cfg_word

  function automatic spi_chan_cfg_t cfg_of(input logic [31:0] w);
    spi_chan_cfg_t c;
    c.enable = w[SPI_IE_LSB +: SPI_IE_W];
    c.gate = w[SPI_GATE_BIT];
    c.desig = spi_desig_t'(w[SPI_DESIG_LSB +: SPI_DESIG_W]);
    return c;
  endfunction : cfg_of

  localparam spi_chan_cfg_t CFG_RST = cfg_of(SPI_CTRL_RST);

  // write lands only on the edge that also sees pready high
  assign wr = psel && penable && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q[0] <= CFG_RST;
      cfg_q[1] <= CFG_RST;
      mask_q <= SPI_MASK_RST[1:0];
    end else if (ce && wr) begin
      if (paddr == SPI_CH0_CTRL_OFF) begin
        cfg_q[0] <= cfg_of(pwdata);
      end else if (paddr == SPI_CH1_CTRL_OFF) begin
        cfg_q[1] <= cfg_of(pwdata);
      end else if (paddr == SPI_MASK_OFF) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // source register: write 1 raises a condition, write to bits 7:4 services
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src_set[i] = '0;
      src_clr[i] = '0;
    end
    if (wr && paddr == SPI_CH0_SRC_OFF) begin
      src_set[0] = pwdata[SPI_SET_LSB +: SPI_SRC_W];
      src_clr[0] = pwdata[SPI_SVC_LSB +: SPI_SRC_W];
    end else if (wr && paddr == SPI_CH1_SRC_OFF) begin
      src_set[1] = pwdata[SPI_SET_LSB +: SPI_SRC_W];
      src_clr[1] = pwdata[SPI_SVC_LSB +: SPI_SRC_W];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_chan
    spi_chan_req u_req (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .cfg(cfg_q[g]),
      .src_set(src_set[g]),
      .src_clr(src_clr[g]),
      .src_q(src_q[g]),
      .req(req[g])
    );
  end

  // line drive: a channel's gate owns the enable of its line
  always_comb begin
    a_d = 1'b0;
    a_oe_d = 1'b0;
    b_d = 1'b0;
    b_oe_d = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (on_line_a(cfg_q[i].desig)) begin
        a_d = a_d | req[i];
        a_oe_d = a_oe_d | cfg_q[i].gate;
      end else begin
        b_d = b_d | req[i];
        b_oe_d = b_oe_d | cfg_q[i].gate;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq_line_a <= 1'b0;
      serial_irq_line_b <= 1'b0;
      serial_irq_line_a_oe <= 1'b0;
      serial_irq_line_b_oe <= 1'b0;
    end else if (ce) begin
      serial_irq_line_a <= a_d;
      serial_irq_line_b <= b_d;
      serial_irq_line_a_oe <= a_oe_d;
      serial_irq_line_b_oe <= b_oe_d;
    end
  end

  // sticky status on each rising channel request; set beats write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_q <= '0;
      stat_q <= '0;
    end else if (ce) begin
      req_prev_q <= req;
      stat_q <= (stat_q & ~((wr && paddr == SPI_STAT_OFF) ? pwdata[1:0] : 2'h0))
                | (req & ~req_prev_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_q & mask_q);
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rdata_d = '0;
    if (paddr == SPI_CH0_CTRL_OFF) begin
      rdata_d = cfg_word(cfg_q[0]);
    end else if (paddr == SPI_CH1_CTRL_OFF) begin
      rdata_d = cfg_word(cfg_q[1]);
    end else if (paddr == SPI_CH0_SRC_OFF) begin
      rdata_d = {28'h0, src_q[0]};
    end else if (paddr == SPI_CH1_SRC_OFF) begin
      rdata_d = {28'h0, src_q[1]};
    end else if (paddr == SPI_LINE_OFF) begin
      rdata_d = {28'h0, b_oe_d, b_d, a_oe_d, a_d};
    end else if (paddr == SPI_STAT_OFF) begin
      rdata_d = {30'h0, stat_q};
    end else if (paddr == SPI_MASK_OFF) begin
      rdata_d = {30'h0, mask_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // answer one cycle after psel; keyed on pready so a low ce only delays it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !rd_ok;
      if (psel && !pready && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // enables stay low while no gate of a channel routed to each line is set
  gate_tristate_a: assert property (
    ce && !(cfg_q[0].gate && on_line_a(cfg_q[0].desig))
    && !(cfg_q[1].gate && on_line_a(cfg_q[1].desig))
    |=> !serial_irq_line_a_oe)
    else $error("line a driven while no gate set");
  gate_tristate_b_a: assert property (
    ce && !(cfg_q[0].gate && !on_line_a(cfg_q[0].desig))
    && !(cfg_q[1].gate && !on_line_a(cfg_q[1].desig))
    |=> !serial_irq_line_b_oe)
    else $error("line b driven while no gate set");
  req_high_a: assert property (
    ce && req[0] && on_line_a(cfg_q[0].desig) |=> serial_irq_line_a)
    else $error("channel 0 request missing on line a");
  route_b_a: assert property (
    ce && req[1] && !on_line_a(cfg_q[1].desig) |=> serial_irq_line_b)
    else $error("channel 1 request missing on line b");
  no_req_low_a: assert property (
    ce && (req == 2'h0) |=> !serial_irq_line_a && !serial_irq_line_b)
    else $error("line high with no request");
  route_a_a: assert property (
    ce && req[1] && on_line_a(cfg_q[1].desig) |=> serial_irq_line_a)
    else $error("channel 1 request missing on line a");
  active_high_a: assert property (
    $past(ce) && serial_irq_line_b
    |-> $past(req[0] && !on_line_a(cfg_q[0].desig)
              || req[1] && !on_line_a(cfg_q[1].desig)))
    else $error("line b high without cause");
  service_clr_a: assert property (
    ce && src_clr[0][0] && !src_set[0][0] |=> !src_q[0][0])
    else $error("service did not clear source");
  gate_req_a: assert property (
    !cfg_q[0].gate |-> !req[0])
    else $error("request with gate clear");
endmodule : spi_irq_out
`default_nettype wire

// ### bench/spi_host_pic.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_pic (
  input wire logic pclk,
  input wire logic line,
  input wire logic oe,
  output logic level
);
  logic last_q = 1'b0;
  // released wire keeps no stale level: show the inverse of the last driven
  assign level = oe ? line : ~last_q;
  always_ff @(posedge pclk) begin
    if (oe) begin
      last_q <= line;
    end
  end
endmodule : spi_host_pic
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import spi_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, la, la_oe, lb, lb_oe, irq, wa, wb, er, g;
  logic [3:0] en, s, e1, s1, x0, x1;
  logic [1:0] d1;
  logic g1, ce = 1'b1;
  int n_errors = 0, comparisons = 0;
  always #5 pclk = ~pclk;
  spi_irq_out dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_irq_line_a(la), .serial_irq_line_a_oe(la_oe),
    .serial_irq_line_b(lb), .serial_irq_line_b_oe(lb_oe), .irq(irq));
  spi_host_pic pic_a (.pclk(pclk), .line(la), .oe(la_oe), .level(wa));
  spi_host_pic pic_b (.pclk(pclk), .line(lb), .oe(lb_oe), .level(wb));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // settled view of both lines, plus what the controller sees
  task automatic look(input logic [3:0] e);
    #1;
    chk("lines", {lb_oe, lb, la_oe, la}, e);
    chk("wire", {wb & lb_oe, wa & la_oe}, {lb & lb_oe, la & la_oe});
    @(posedge pclk);
  endtask : look
  function automatic logic [3:0] exl(logic [1:0] d, logic [3:0] e,
                                     logic gt, logic [3:0] sr);
    logic on;
    on = gt & |(e & sr);
    return d[0] ? {2'b00, gt, on} : {gt, on, 2'b00};
  endfunction : exl
  function automatic logic [31:0] cw(logic [1:0] d, logic gt,
                                     logic [3:0] e);
    cw = '0;
    cw[SPI_IE_LSB +: SPI_IE_W] = e;
    cw[SPI_GATE_BIT] = gt;
    cw[SPI_DESIG_LSB +: SPI_DESIG_W] = d;
  endfunction : cw
  task automatic results();
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(32'hB3530E87));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    look(4'h0);
    apb(0, SPI_CH0_CTRL_OFF, 0);
    chk("ctrl_rst", rd, SPI_CTRL_RST);
    for (int i = 0; i < 24; i++) begin
      en = 4'($urandom);
      s = 4'($urandom);
      g = 1'((i < 4) | $urandom);
      e1 = 4'($urandom);
      s1 = 4'($urandom);
      g1 = 1'($urandom);
      d1 = 2'($urandom);
      if (i < 4) begin
        en = 4'(1 << i);
        s = en;
      end
      apb(1, SPI_CH0_SRC_OFF, 32'hF0);
      apb(1, SPI_CH1_SRC_OFF, 32'hF0);
      apb(1, SPI_CH0_CTRL_OFF, cw(i[1:0], g, en));
      apb(1, SPI_CH1_CTRL_OFF, cw(d1, g1, e1));
      apb(1, SPI_CH0_SRC_OFF, {28'h0, s});
      apb(1, SPI_CH1_SRC_OFF, {28'h0, s1});
      x0 = exl(i[1:0], en, g, s);
      x1 = exl(d1, e1, g1, s1);
      look(x0 | x1);
      apb(0, SPI_LINE_OFF, 0);
      chk("line_view", rd, {28'h0, x0 | x1});
      apb(0, SPI_CH1_SRC_OFF, 0);
      chk("src_pend", rd, {28'h0, s1});
      apb(1, SPI_CH0_CTRL_OFF, cw(i[1:0], g, 4'h0));
      look(exl(i[1:0], 4'h0, g, s) | x1);
      apb(1, SPI_CH0_CTRL_OFF, cw(i[1:0], g, en));
      apb(1, SPI_CH0_SRC_OFF, {24'h0, s, 4'h0});
      look(exl(i[1:0], en, g, 4'h0) | x1);
    end
    apb(1, SPI_CH1_SRC_OFF, 32'hF0);
    x1 = exl(d1, e1, g1, 4'h0);
    apb(1, SPI_STAT_OFF, 32'h3);
    apb(1, SPI_MASK_OFF, 32'h1);
    apb(1, SPI_CH0_CTRL_OFF, 32'h1F);
    apb(1, SPI_CH0_SRC_OFF, 32'h2);
    apb(0, SPI_STAT_OFF, 0);
    chk("stat_set", rd, 32'h1);
    chk("irq_on", irq, 1'b1);
    apb(1, SPI_MASK_OFF, 32'h0);
    #1;
    chk("irq_mask", irq, 1'b0);
    @(posedge pclk);
    apb(1, SPI_STAT_OFF, 32'h1);
    apb(0, SPI_STAT_OFF, 0);
    chk("stat_w1c", rd, 32'h0);
    // a low clock enable stalls a service write and holds the line
    ce <= 1'b0;
    fork
      apb(1, SPI_CH0_SRC_OFF, 32'hF0);
      begin
        repeat (3) @(posedge pclk);
        #1;
        chk("ce_hold", {pready, lb}, 2'b01);
        @(posedge pclk);
        ce <= 1'b1;
      end
    join
    look(exl(2'h0, 4'hF, 1'b1, 4'h0) | x1);
    apb(0, 12'h0FC, 0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    presetn <= 1'b0;
    look(4'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    look(4'h0);
    chk("irq_rst", irq, 1'b0);
    apb(0, SPI_CH0_CTRL_OFF, 0);
    chk("ctrl_rst2", rd, SPI_CTRL_RST);
    results();
  end
endmodule : tb
`default_nettype wire
